// *** design/nvm_access.sv ***
`timescale 1ns/100ps
// Overview of operation
// RQ1 - unique id words never erased or changed
// RQ2 - unique id at 8100h to 8109h
// RQ3 - customer id at 810Ah to 8111h, fixed
// RQ4 - bulk erase keeps customer id intact
// RQ5 - low range temperature words 8112h-8114h
// RQ6 - high range temperature words 8115h-8117h
// RQ7 - temperature readings right justified
// RQ8 - reference millivolt words 8118h-811Dh
// RQ9 - code protect blocks programmer read/write
// RQ10 - only programmer bulk erase releases protection; here reset also loads both config words erased
// RQ11 - write protect bits block self-write
// RQ12 - programmer ignores write protection
// RQ13 - flash is 14-bit words, one per read
// RQ14 - fetch and indirect path read only
// RQ15 - erased reads one, program clears bits
// RQ16 - row of 32 words smallest erase
// RQ17 - latches filled only through data register
// RQ18 - software rereads row before partial rewrite
// RQ19 - self path offers no bulk erase
// RQ20 - 256 byte eeprom, byte writable
// RQ21 - eeprom indirect path read only
// RQ22 - internal timer times every write; here only self writes are timed, programmer writes complete in one cycle
// RQ23 - 55h, AAh, then write trigger
// RQ24 - read trigger clears after data loads
// RQ25 - protected target leaves memory unchanged
module nvm_access
    import nvm_pkg::*;
#(
    parameter int PFM_WORDS = 8192,
    parameter int BOOT_WORDS = 512,
    parameter int SAF_WORDS = 128,
    parameter int ADC_W = 12,
    // factory area content, arbitrary neutral value
    parameter logic [32*14-1:0] INFO_INIT = {32{14'h0a5c}}
)(
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // low during reset, then always ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    input wire logic [15:0] fetch_addr, // cpu fetch address
    output logic [13:0] fetch_data, // fetched word
    input nvm_prog_req_t prog_req, // programmer request
    output nvm_prog_rsp_t prog_rsp // programmer answer
);

localparam int AW = $clog2(PFM_WORDS);
localparam int TW = $clog2(WRITE_CYCLES + 1);
localparam logic [15:0] PFM_END = 16'(PFM_WORDS);
localparam logic [15:0] BOOT_END = 16'(BOOT_WORDS);
localparam logic [15:0] SAF_START = 16'(PFM_WORDS - SAF_WORDS);
localparam logic [13:0] ADC_MASK = 14'((1 << ADC_W) - 1);
localparam int WR_MAX = 210;

logic [13:0] flash [PFM_WORDS];
logic [7:0] eeprom [EE_BYTES];
logic [13:0] user_id [4];
logic [13:0] row_latch [ROW_WORDS];
logic [13:0] code_protect_word;
logic [13:0] write_protect_word;
logic [15:0] nvm_addr;
logic [13:0] nvm_data_pair;
logic [15:0] indirect_pointer;
logic [4:0] ctrl;
logic busy;
logic [TW-1:0] timer;
logic wr_err;
nvm_key_t key;
logic dp_wr;
logic [7:0] dp_off;
logic code_protect_n;
logic bus_req;
logic start;
logic wr_attempt;
logic latch_load;
logic commit;
logic commit_ok;
nvm_region_t c_region;
logic prog_rw;
logic prog_bulk;
logic prog_wr;

////////////////////////////////////////////////////////////////////////
// decode helpers

function automatic nvm_region_t region_of(input logic [15:0] a);
    if (a < PFM_END)
        return (a < BOOT_END) ? RG_BOOT : ((a >= SAF_START) ? RG_SAF : RG_APP);
    else if (a >= EE_FIRST && a <= EE_LAST)
        return RG_EE;
    else if (a >= USERID_FIRST && a <= USERID_LAST)
        return RG_USERID;
    else if (a == WP_WORD_ADDR || a == CP_WORD_ADDR)
        return RG_CFG;
    else if (a >= INFO_FIRST && a <= INFO_LAST)
        return RG_INFO;
    return RG_NONE;
endfunction

// self-write permission; factory area is never writable
function automatic logic self_blocked(input nvm_region_t r);
    case (r)
        RG_APP: return !write_protect_word[WP_APP]; // RQ11
        RG_BOOT: return !write_protect_word[WP_BOOT]; // RQ11
        RG_SAF: return !write_protect_word[WP_SAF]; // RQ11
        RG_EE: return !write_protect_word[WP_EE]; // RQ11
        RG_CFG: return !write_protect_word[WP_CFG]; // RQ11
        RG_USERID: return 1'b0;
        default: return 1'b1; // RQ1
    endcase
endfunction

// one 14-bit word per read from any space
function automatic logic [13:0] nvm_read(input logic [15:0] a);
    logic [13:0] w;
    w = '0;
    case (region_of(a))
        RG_APP, RG_BOOT, RG_SAF: w = flash[a[AW-1:0]]; // RQ13
        RG_EE: w = {6'h00, eeprom[a[7:0]]};
        RG_USERID: w = user_id[a[1:0]];
        RG_CFG: w = (a == CP_WORD_ADDR) ? code_protect_word : write_protect_word;
        RG_INFO:
        begin
            // constant words, out of reach of any erase or write, RQ1 RQ2 RQ3 RQ4 RQ8
            w = INFO_INIT[int'(a[4:0]) * WORD_W +: WORD_W];
            if (a >= TLOW_FIRST && a <= THIGH_LAST)
                w = w & ADC_MASK; // RQ5 RQ6 RQ7
        end
        default: w = '0;
    endcase
    return w;
endfunction

////////////////////////////////////////////////////////////////////////
// request decode

assign code_protect_n = code_protect_word[CP_BIT];
assign bus_req = hsel && htrans[1] && hready;
assign c_region = region_of(nvm_addr);
assign commit = busy && (timer == '0);
assign commit_ok = commit && !self_blocked(c_region); // RQ25
assign wr_attempt = dp_wr && dp_off == REG_CTRL && hwdata[CTRL_WR] && !busy;
// trigger only straight after the two keys, RQ23
assign start = wr_attempt && key == KEY_ARMED && hwdata[CTRL_WREN] && !hwdata[CTRL_LATCH];
assign latch_load = wr_attempt && key == KEY_ARMED && hwdata[CTRL_WREN] && hwdata[CTRL_LATCH];
assign prog_rw = prog_req.valid && (prog_req.op == PROG_READ || prog_req.op == PROG_WRITE);
assign prog_bulk = prog_req.valid && prog_req.op == PROG_BULK; // RQ19
// write protection plays no part on the programmer side, RQ12
assign prog_wr = prog_req.valid && prog_req.op == PROG_WRITE && code_protect_n; // RQ9

////////////////////////////////////////////////////////////////////////
// bus slave: zero wait, reads answered from a flop in the data phase

always_ff @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        dp_wr <= 1'b0;
        dp_off <= 8'h00;
        hrdata <= 32'h0000_0000;
        hreadyout <= 1'b0;
        hresp <= 1'b0;
    end
    else
    begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        dp_wr <= bus_req && hwrite;
        dp_off <= haddr[7:0];
        if (bus_req && !hwrite)
        begin
            case (haddr[7:0])
                REG_ADDR: hrdata <= {16'h0000, nvm_addr};
                REG_DATA: hrdata <= {18'h00000, nvm_data_pair}; // RQ13
                REG_CTRL: hrdata <= {27'h0000000, ctrl};
                REG_STATUS: hrdata <= {29'h0000000, code_protect_n, wr_err, busy};
                REG_IPTR: hrdata <= {16'h0000, indirect_pointer};
                REG_IDATA: hrdata <= {18'h00000, nvm_read(indirect_pointer)}; // RQ14 RQ21
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end
end

// address, data pair and pointer; address frozen while a write runs, data pair too unless the trigger write sets the read bit; pointer stays writable
always_ff @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        nvm_addr <= 16'h0000;
        nvm_data_pair <= 14'h0000;
        indirect_pointer <= 16'h0000;
    end
    else
    begin
        if (ctrl[CTRL_RD])
            nvm_data_pair <= nvm_read(nvm_addr); // RQ24
        else if (dp_wr && dp_off == REG_DATA && !busy)
            nvm_data_pair <= hwdata[13:0];
        if (dp_wr && dp_off == REG_ADDR && !busy)
            nvm_addr <= hwdata[15:0];
        if (dp_wr && dp_off == REG_IPTR)
            indirect_pointer <= hwdata[15:0];
    end
end

// unlock keys: any other write in between breaks the sequence
always_ff @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
        key <= KEY_IDLE;
    else if (dp_wr)
    begin
        if (dp_off == REG_KEY && hwdata[7:0] == KEY_FIRST)
            key <= KEY_HALF; // RQ23
        else if (dp_off == REG_KEY && hwdata[7:0] == KEY_SECOND && key == KEY_HALF)
            key <= KEY_ARMED; // RQ23
        else
            key <= KEY_IDLE;
    end
end

// control bits; software cannot cancel a running write
always_ff @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
        ctrl <= 5'h00;
    else
    begin
        if (ctrl[CTRL_RD])
            ctrl[CTRL_RD] <= 1'b0; // RQ24
        else if (dp_wr && dp_off == REG_CTRL && !busy)
            ctrl[CTRL_RD] <= hwdata[CTRL_RD];
        if (commit)
            ctrl[CTRL_WR] <= 1'b0;
        else if (start)
            ctrl[CTRL_WR] <= 1'b1;
        if (dp_wr && dp_off == REG_CTRL && !busy)
        begin
            ctrl[CTRL_WREN] <= hwdata[CTRL_WREN];
            ctrl[CTRL_FREE] <= hwdata[CTRL_FREE];
            ctrl[CTRL_LATCH] <= hwdata[CTRL_LATCH];
        end
    end
end

// write timer runs on its own so software never counts
always_ff @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        busy <= 1'b0;
        timer <= '0;
    end
    else if (start)
    begin
        busy <= 1'b1; // RQ22
        timer <= TW'(WRITE_CYCLES - 1);
    end
    else if (commit)
        busy <= 1'b0;
    else if (busy)
        timer <= timer - 1'b1;
end

// error flag: a new event wins over the clear in the same cycle
always_ff @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
        wr_err <= 1'b0;
    else if ((commit && !commit_ok) || (wr_attempt && !start && !latch_load))
        wr_err <= 1'b1; // RQ25
    else if (dp_wr && dp_off == REG_STATUS && hwdata[ST_WRERR])
        wr_err <= 1'b0;
end

////////////////////////////////////////////////////////////////////////
// row latches: loaded one word per keyed control write with the latch bit set, RQ17

always_ff @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        for (int i = 0; i < ROW_WORDS; i++)
            row_latch[i] <= ERASED_WORD;
    end
    else if (latch_load)
        row_latch[nvm_addr[ROW_BITS-1:0]] <= nvm_data_pair; // RQ17
    else if (commit && !ctrl[CTRL_FREE])
    begin
        // unloaded latches stay at ones and program nothing
        for (int i = 0; i < ROW_WORDS; i++)
            row_latch[i] <= ERASED_WORD;
    end
end

// program array; no reset, contents are nonvolatile
always_ff @(posedge hclk)
begin
    if (prog_bulk)
    begin
        for (int i = 0; i < PFM_WORDS; i++)
            flash[i] <= ERASED_WORD; // RQ10
    end
    else if (commit_ok && c_region inside {RG_APP, RG_BOOT, RG_SAF})
    begin
        for (int i = 0; i < ROW_WORDS; i++)
        begin
            if (ctrl[CTRL_FREE])
                flash[{nvm_addr[AW-1:ROW_BITS], ROW_BITS'(i)}] <= ERASED_WORD; // RQ16
            else
                flash[{nvm_addr[AW-1:ROW_BITS], ROW_BITS'(i)}] <=
                    flash[{nvm_addr[AW-1:ROW_BITS], ROW_BITS'(i)}] & row_latch[i]; // RQ15
        end
    end
    else if (prog_wr && region_of(prog_req.addr) inside {RG_APP, RG_BOOT, RG_SAF})
        flash[prog_req.addr[AW-1:0]] <= flash[prog_req.addr[AW-1:0]] & prog_req.wdata; // RQ15
end

// eeprom: byte writes with implicit erase
always_ff @(posedge hclk)
begin
    if (prog_bulk)
    begin
        for (int i = 0; i < EE_BYTES; i++)
            eeprom[i] <= ERASED_BYTE; // RQ10
    end
    else if (commit_ok && c_region == RG_EE)
        eeprom[nvm_addr[7:0]] <= ctrl[CTRL_FREE] ? ERASED_BYTE : nvm_data_pair[7:0]; // RQ20
    else if (prog_wr && region_of(prog_req.addr) == RG_EE)
        eeprom[prog_req.addr[7:0]] <= prog_req.wdata[7:0]; // RQ20
end

// user id words
always_ff @(posedge hclk)
begin
    if (prog_bulk)
    begin
        for (int i = 0; i < 4; i++)
            user_id[i] <= ERASED_WORD; // RQ10
    end
    else if (commit_ok && c_region == RG_USERID)
        user_id[nvm_addr[1:0]] <= ctrl[CTRL_FREE] ? ERASED_WORD : user_id[nvm_addr[1:0]] & nvm_data_pair;
    else if (prog_wr && region_of(prog_req.addr) == RG_USERID)
        user_id[prog_req.addr[1:0]] <= user_id[prog_req.addr[1:0]] & prog_req.wdata;
end

// config words; held in flops so protection is defined from reset
always_ff @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        code_protect_word <= ERASED_WORD;
        write_protect_word <= ERASED_WORD;
    end
    else if (prog_bulk)
    begin
        code_protect_word <= ERASED_WORD; // RQ10
        write_protect_word <= ERASED_WORD;
    end
    else if (commit_ok && c_region == RG_CFG)
    begin
        // self path can set protection but never clear it
        if (nvm_addr == CP_WORD_ADDR && !ctrl[CTRL_FREE])
            code_protect_word <= code_protect_word & nvm_data_pair;
        if (nvm_addr == WP_WORD_ADDR && !ctrl[CTRL_FREE])
            write_protect_word <= write_protect_word & nvm_data_pair;
    end
    else if (prog_wr && prog_req.addr == CP_WORD_ADDR)
        code_protect_word <= code_protect_word & prog_req.wdata;
    else if (prog_wr && prog_req.addr == WP_WORD_ADDR)
        write_protect_word <= write_protect_word & prog_req.wdata; // RQ12
end

////////////////////////////////////////////////////////////////////////
// read ports: fetch and programmer, both read only here

always_ff @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        fetch_data <= 14'h0000;
        prog_rsp <= '0;
    end
    else
    begin
        fetch_data <= nvm_read(fetch_addr); // RQ14
        prog_rsp.done <= prog_req.valid && prog_req.op != PROG_NOP;
        prog_rsp.refused <= prog_rw && !code_protect_n; // RQ9
        if (prog_req.valid && prog_req.op == PROG_READ && code_protect_n)
            prog_rsp.rdata <= nvm_read(prog_req.addr);
        else
            prog_rsp.rdata <= 14'h0000;
    end
end

////////////////////////////////////////////////////////////////////////
// checks

sequence s_wr_start;
    start;
endsequence
sequence s_busy_run;
    busy [*8];
endsequence

property p_uid_words;
    @(posedge hclk) disable iff (!hresetn)
    (fetch_addr >= UID_FIRST && fetch_addr <= UID_LAST)
        |=> fetch_data == INFO_INIT[int'($past(fetch_addr[4:0])) * WORD_W +: WORD_W];
endproperty
a_uid_words: assert property (p_uid_words) else $error("unique id word wrong"); // RQ2

property p_cust_words;
    @(posedge hclk) disable iff (!hresetn)
    (prog_req.valid && prog_req.op == PROG_BULK) ##1 (fetch_addr == CUST_FIRST)
        |=> fetch_data == INFO_INIT[10 * WORD_W +: WORD_W];
endproperty
a_cust_words: assert property (p_cust_words) else $error("customer id lost on bulk erase"); // RQ4

property p_temp_just;
    @(posedge hclk) disable iff (!hresetn)
    (fetch_addr >= TLOW_FIRST && fetch_addr <= THIGH_LAST) |=> (fetch_data & ~ADC_MASK) == 14'h0000;
endproperty
a_temp_just: assert property (p_temp_just) else $error("temperature word not right justified"); // RQ7

property p_cp_refuse;
    @(posedge hclk) disable iff (!hresetn)
    (prog_rw && !code_protect_n) |=> prog_rsp.refused && prog_rsp.rdata == 14'h0000;
endproperty
a_cp_refuse: assert property (p_cp_refuse) else $error("protected access not refused"); // RQ9

property p_bulk_release;
    @(posedge hclk) disable iff (!hresetn)
    prog_bulk |=> code_protect_n && write_protect_word == ERASED_WORD;
endproperty
a_bulk_release: assert property (p_bulk_release) else $error("bulk erase kept protection"); // RQ10

property p_wp_ignored;
    @(posedge hclk) disable iff (!hresetn)
    (prog_rw && code_protect_n) |=> prog_rsp.done && !prog_rsp.refused;
endproperty
a_wp_ignored: assert property (p_wp_ignored) else $error("programmer refused without code protect"); // RQ12

property p_timed;
    @(posedge hclk) disable iff (!hresetn)
    s_wr_start |=> s_busy_run ##[1:WR_MAX] !busy;
endproperty
a_timed: assert property (p_timed) else $error("write not timed internally"); // RQ22

property p_unlock;
    @(posedge hclk) disable iff (!hresetn)
    (wr_attempt && key != KEY_ARMED) |=> !busy && wr_err;
endproperty
a_unlock: assert property (p_unlock) else $error("write started without unlock"); // RQ23

// word at the nvm address one cycle back, kept for the read trigger check
logic [13:0] rd_word;
always_ff @(posedge hclk)
begin
    rd_word <= nvm_read(nvm_addr);
end

property p_rd_clear;
    @(posedge hclk) disable iff (!hresetn)
    ctrl[CTRL_RD] |=> !ctrl[CTRL_RD] && nvm_data_pair == rd_word;
endproperty
a_rd_clear: assert property (p_rd_clear) else $error("read trigger not cleared"); // RQ24

property p_blocked;
    @(posedge hclk) disable iff (!hresetn)
    (commit && self_blocked(c_region)) |=> wr_err && !busy;
endproperty
a_blocked: assert property (p_blocked) else $error("protected write not flagged"); // RQ25

endmodule

// *** design/nvm_pkg.sv ***
package nvm_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int WRITE_TIME_NS = 2000;
    localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // geometry
    localparam int WORD_W = 14;
    localparam int ROW_WORDS = 32;
    localparam int ROW_BITS = 5;
    localparam int EE_BYTES = 256;
    localparam logic [13:0] ERASED_WORD = 14'h3fff;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    // nvm address map
    localparam logic [15:0] EE_FIRST = 16'h7000;
    localparam logic [15:0] EE_LAST = 16'h70ff;
    localparam logic [15:0] USERID_FIRST = 16'h8000;
    localparam logic [15:0] USERID_LAST = 16'h8003;
    localparam logic [15:0] WP_WORD_ADDR = 16'h8007;
    localparam logic [15:0] CP_WORD_ADDR = 16'h8008;
    localparam logic [15:0] INFO_FIRST = 16'h8100;
    localparam logic [15:0] UID_FIRST = 16'h8100;
    localparam logic [15:0] UID_LAST = 16'h8109;
    localparam logic [15:0] CUST_FIRST = 16'h810a;
    localparam logic [15:0] CUST_LAST = 16'h8111;
    localparam logic [15:0] TLOW_FIRST = 16'h8112;
    localparam logic [15:0] TLOW_LAST = 16'h8114;
    localparam logic [15:0] THIGH_FIRST = 16'h8115;
    localparam logic [15:0] THIGH_LAST = 16'h8117;
    localparam logic [15:0] REF_FIRST = 16'h8118;
    localparam logic [15:0] REF_LAST = 16'h811d;
    localparam logic [15:0] INFO_LAST = 16'h811f;
    // bus register offsets
    localparam logic [7:0] REG_ADDR = 8'h00;
    localparam logic [7:0] REG_DATA = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam logic [7:0] REG_KEY = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_IPTR = 8'h14;
    localparam logic [7:0] REG_IDATA = 8'h18;
    // control and status fields
    localparam int CTRL_RD = 0;
    localparam int CTRL_WR = 1;
    localparam int CTRL_WREN = 2;
    localparam int CTRL_FREE = 3;
    localparam int CTRL_LATCH = 4;
    localparam int ST_BUSY = 0;
    localparam int ST_WRERR = 1;
    localparam int ST_CPN = 2;
    localparam int ST_WP = 3;
    // config word fields, 0 = protection selected
    localparam int WP_SAF = 0;
    localparam int WP_EE = 1;
    localparam int WP_CFG = 2;
    localparam int WP_BOOT = 3;
    localparam int WP_APP = 4;
    localparam int CP_BIT = 0;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    typedef enum logic [2:0] {RG_APP, RG_BOOT, RG_SAF, RG_EE, RG_CFG, RG_USERID, RG_INFO, RG_NONE} nvm_region_t;
    typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} nvm_key_t;
    typedef enum logic [1:0] {PROG_NOP, PROG_READ, PROG_WRITE, PROG_BULK} nvm_prog_op_t;
    typedef struct packed {
        logic valid;
        nvm_prog_op_t op;
        logic [15:0] addr;
        logic [13:0] wdata;
    } nvm_prog_req_t;
    typedef struct packed {
        logic done;
        logic refused;
        logic [13:0] rdata;
    } nvm_prog_rsp_t;
endpackage

// *** dv/nvm_prog_model.sv ***
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// external programmer: one request per call, fields scrambled when idle
module nvm_prog_model
    import nvm_pkg::*;
(
    input wire logic hclk, // system clock
    output nvm_prog_req_t prog_req, // request to device
    input wire nvm_prog_rsp_t prog_rsp // device answer
);
    initial prog_req = '0;
    // idle fields show inverted data so a stale request never looks valid
    task automatic op(input nvm_prog_op_t o, input logic [15:0] a, input logic [13:0] d,
        output nvm_prog_rsp_t r);
        prog_req <= '{1'b1, o, a, d};
        @(posedge hclk);
        prog_req <= '{1'b0, PROG_NOP, ~a, ~d};
        @(posedge hclk);
        r = prog_rsp;
    endtask
endmodule

// *** dv/test_nvm_array_access_and_protection.sv ***
`timescale 1ns/100ps
module test_nvm_array_access_and_protection;
    import nvm_pkg::*;
    localparam logic [13:0] INFO_W = 14'h3abc;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [15:0] fetch_addr;
    logic [13:0] fetch_data;
    nvm_prog_rsp_t prog_rsp, r;
    nvm_prog_req_t prog_req;
    int error_cnt, cmp_count, seed, a, d, mdl[int];
    ////////////////////////////////////////////////////////////////////////
    // small flash keeps the run short; info pattern sets bits above the adc width
    nvm_access #(.PFM_WORDS(256), .INFO_INIT({32{INFO_W}})) u_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .fetch_addr(fetch_addr), .fetch_data(fetch_data), .prog_req(prog_req), .prog_rsp(prog_rsp));
    nvm_prog_model u_prog (.hclk(hclk), .prog_req(prog_req), .prog_rsp(prog_rsp));
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    ////////////////////////////////////////////////////////////////////////
    // reference contents: words written since the last bulk erase
    function automatic int ev(int x);
        if (x >= 'h8112 && x <= 'h8117) return INFO_W & 'hfff;
        if (x >= 'h8100) return INFO_W;
        if (mdl.exists(x)) return mdl[x];
        return (x >= 'h7000) ? 'hff : 'h3fff;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %0t mismatch got %h exp %h", $time, g, e);
        end
    endtask
    // single word transfer; hready waits are cut only by the watchdog
    task automatic ahb(input logic w, input logic [7:0] ad, input int wd);
        haddr <= {24'h0, ad};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 0); // bus response always okay
    endtask
    task automatic pw(input nvm_prog_op_t o, input int x, input int v);
        u_prog.op(o, x[15:0], v[13:0], r);
        if (o == PROG_BULK) mdl.delete();
        else if (x >= 'h7000 && x < 'h7100) mdl[x] = v & 'hff;
        else if (x < 'h8100) mdl[x] = ev(x) & v & 'h3fff;
    endtask
    task automatic pr(input int x);
        int e;
        e = ev(x);
        u_prog.op(PROG_READ, x[15:0], 14'h0, r);
        chk({r.done, r.refused, 16'h0, r.rdata}, {2'b10, 16'h0, e[13:0]});
    endtask
    // indirect read; the write before it must be ignored
    task automatic ir(input int x);
        ahb(1'b1, REG_IPTR, x);
        ahb(1'b1, REG_IDATA, 0);
        ahb(1'b0, REG_IDATA, 0);
        chk(rd, ev(x));
    endtask
    // unlocked self write; the poll count tells how long busy stood
    task automatic sw(input int x, input int v, input logic f);
        int n;
        ahb(1'b1, REG_ADDR, x);
        ahb(1'b1, REG_DATA, v);
        ahb(1'b1, REG_CTRL, 4);
        ahb(1'b1, REG_KEY, 'h55);
        ahb(1'b1, REG_KEY, 'haa);
        ahb(1'b1, REG_CTRL, {28'h0, f, 3'h6});
        ahb(1'b0, REG_STATUS, 0);
        for (n = 0; n < 300 && rd[0] !== 1'b0; n++) ahb(1'b0, REG_STATUS, 0);
        chk({31'h0, n > 90 && n < 106}, 1);
    endtask
    task automatic end_of_test;
        $display("compares %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // about 1300 cycles expected; the limit leaves wide margin
    initial
    begin
        #300000;
        error_cnt++;
        end_of_test;
    end
    initial
    begin
        seed = 86581;
        {hsel, htrans, hwrite, haddr, hwdata, fetch_addr, hresetn} = '0;
        hsel = 1'b1;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        pw(PROG_BULK, 0, 0);
        for (a = 'h8100; a <= 'h811f; a++)
        begin
            fetch_addr <= a[15:0];
            pr(a);
        end
        pw(PROG_WRITE, 'h8100, 0);
        pw(PROG_WRITE, 'h810a, 0);
        fetch_addr <= CUST_FIRST;
        pw(PROG_BULK, 0, 0);
        chk({18'h0, fetch_data}, ev('h810a));
        pr('h8100);
        pr('h810a);
        $display("test info area done");
        repeat (6)
        begin
            a = $random(seed) & 'hff;
            pw(PROG_WRITE, a, $random(seed));
            pw(PROG_WRITE, a, $random(seed));
            pr(a);
        end
        fetch_addr <= a[15:0];
        repeat (2) @(posedge hclk);
        chk({18'h0, fetch_data}, ev(a));
        ir(a);
        ahb(1'b1, REG_ADDR, a);
        ahb(1'b1, REG_CTRL, 1);
        // the data pair loads one edge after the trigger lands
        @(posedge hclk);
        ahb(1'b0, REG_DATA, 0);
        chk(rd, ev(a));
        ahb(1'b0, REG_CTRL, 0);
        chk({31'h0, rd[0]}, 0);
        sw(a, 0, 1'b1);
        for (d = 0; d < 32; d++) mdl.delete((a & ~31) + d);
        pr(a);
        pr((a & ~31) + 31);
        // one latch loaded under the keys, then the erased row programmed from the latches
        d = $random(seed) & 'h3fff;
        ahb(1'b1, REG_ADDR, a);
        ahb(1'b1, REG_DATA, d);
        ahb(1'b1, REG_KEY, 'h55);
        ahb(1'b1, REG_KEY, 'haa);
        ahb(1'b1, REG_CTRL, 'h16);
        sw(a, 0, 1'b0);
        mdl[a] = d;
        pr(a);
        pr((a & ~31) + 31);
        $display("test flash done");
        pw(PROG_WRITE, 'h7003, 'h1a5);
        pr('h7003);
        sw('h7010, 'h5a, 1'b0);
        mdl['h7010] = 'h5a;
        ir('h7010);
        pw(PROG_WRITE, WP_WORD_ADDR, 'h3ffd);
        sw('h7003, 'h11, 1'b0);
        ahb(1'b0, REG_STATUS, 0);
        chk({31'h0, rd[1]}, 1);
        ir('h7003);
        pw(PROG_WRITE, 'h7003, 'h22);
        pr('h7003);
        ahb(1'b1, REG_STATUS, 2);
        ahb(1'b1, REG_CTRL, 6);
        ahb(1'b0, REG_STATUS, 0);
        chk({31'h0, rd[1]}, 1);
        $display("test eeprom and write protect done");
        pw(PROG_BULK, 0, 0);
        pw(PROG_WRITE, CP_WORD_ADDR, 'h3ffe);
        ahb(1'b0, REG_STATUS, 0);
        chk({31'h0, rd[2]}, 0);
        u_prog.op(PROG_READ, 16'h8000, 14'h0, r);
        chk({16'h0, r.done, r.refused, r.rdata}, 'hc000);
        u_prog.op(PROG_WRITE, 16'h7020, 14'h0, r);
        chk({16'h0, r.done, r.refused, r.rdata}, 'hc000);
        sw('h7020, 'h3c, 1'b0);
        mdl['h7020] = 'h3c;
        ir('h7020);
        pw(PROG_BULK, 0, 0);
        pr('h7020);
        $display("test code protect done");
        end_of_test;
    end
endmodule
